// [hw/clock_network_pkg.sv]
// constants, types and configuration layout for the clock network control block
package clock_network_pkg;

  localparam int NUM_GLOBAL            = 16;
  localparam int NUM_REGIONAL          = 32;
  localparam int NUM_QUADRANTS         = 4;
  localparam int REGIONAL_PER_QUADRANT = 8;
  localparam int CLOCKS_PER_REGION     = 24;
  localparam int NUM_PINS              = 16;
  localparam int PINS_PER_SIDE         = 4;
  localparam int NUM_PIN_PAIRS         = 8;
  localparam int NUM_PLL_OUT           = 8;

  // where a net takes its clock from
  typedef enum logic [2:0] {
    SRC_PIN   = 3'b001,
    SRC_PLL   = 3'b010,
    SRC_LOGIC = 3'b100
  } src_kind_t;

  // gate state of one clock control cell
  typedef enum logic [1:0] {
    CELL_OFF = 2'b01,
    CELL_ON  = 2'b10
  } cell_state_t;

  // static configuration of one net, fixed while running
  typedef struct packed {
    logic             used;     // low holds the net powered down
    src_kind_t        kind;
    logic [2:0]       pin_pair; // pair n holds pins 2n (input 0) and 2n+1 (input 1)
    logic             pin_odd;  // regional nets: take the odd pin of the pair
    logic [2:0]       pll_sel;
  } net_cfg_t;

  // running state of one clock control cell
  typedef struct packed {
    cell_state_t state;
    logic        sel;
    logic        clk;
  } cell_t;

  // the clocks that reach one quadrant: all globals plus its own regionals
  typedef struct packed {
    logic [NUM_GLOBAL-1:0]            global_clk;
    logic [REGIONAL_PER_QUADRANT-1:0] regional_clk;
  } region_clocks_t;

  localparam cell_t CELL_RESET = '{state: CELL_OFF, sel: 1'b0, clk: 1'b0};

endpackage

// [hw/clock_network_control.sv]
// clock control cells for global, regional and pll output pad networks
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - sixteen global nets and thirty-two regional nets, eight regionals per quadrant.
// - each quadrant receives at most twenty-four clocks: sixteen global, eight regional.
// - sixteen dedicated clock pins, four per side, feed global or regional nets.
// - every net has its own cell choosing its source and gating it.
// - any net may take a dedicated pin, a pll output or internal logic.
// - only global nets switch source at run time, between pins and pll outputs.
// - core logic enables each net and pll pad; enable is applied synchronously.
// - enable gating acts on the net or pad, leaving the pll untouched.
// - a powered-down net delivers no clock edges to its logic.
// - configuration bits statically disable nets; unused nets are powered down.
// - global nets serve as clocks and as control inputs for all resources.
// - every global net reaches all four quadrants.
module clock_network_control
  import clock_network_pkg::*;
(
  input  wire  logic                                   ref_clk,
  input  wire  logic                                   rst,
  input  wire  logic [clock_network_pkg::NUM_PINS-1:0] dedicated_clock_pin,
  input  wire  logic [clock_network_pkg::NUM_PLL_OUT-1:0] pll_clk,
  input  wire  logic [clock_network_pkg::NUM_GLOBAL-1:0] global_logic_clk,
  input  wire  logic [clock_network_pkg::NUM_REGIONAL-1:0] regional_logic_clk,
  input  wire  clock_network_pkg::net_cfg_t [clock_network_pkg::NUM_GLOBAL-1:0] global_cfg,
  input  wire  clock_network_pkg::net_cfg_t [clock_network_pkg::NUM_REGIONAL-1:0] regional_cfg,
  input  wire  logic [clock_network_pkg::NUM_GLOBAL-1:0] global_en,
  input  wire  logic [clock_network_pkg::NUM_GLOBAL-1:0] global_sel,
  input  wire  logic [clock_network_pkg::NUM_REGIONAL-1:0] regional_en,
  input  wire  logic [clock_network_pkg::NUM_PLL_OUT-1:0] pll_pad_en,
  output logic [clock_network_pkg::NUM_GLOBAL-1:0]     global_clock_net,
  output logic [clock_network_pkg::NUM_REGIONAL-1:0]   regional_clock_net,
  output logic [clock_network_pkg::NUM_PLL_OUT-1:0]    pll_out_pad,
  output var clock_network_pkg::region_clocks_t [clock_network_pkg::NUM_QUADRANTS-1:0] region_clocks
);
  import clock_network_pkg::*;

  cell_t [NUM_GLOBAL-1:0]   gcell;
  cell_t [NUM_GLOBAL-1:0]   next_gcell;
  cell_t [NUM_REGIONAL-1:0] rcell;
  cell_t [NUM_REGIONAL-1:0] next_rcell;
  cell_t [NUM_PLL_OUT-1:0]  pcell;
  cell_t [NUM_PLL_OUT-1:0]  next_pcell;
  region_clocks_t [NUM_QUADRANTS-1:0] next_region;

  // one cell step: enable and select change only in a low phase of both clocks
  function automatic cell_t cell_step(input cell_t cur, input logic used, input logic en,
                                      input logic sel_req, input logic in0, input logic in1);
    cell_t nxt;
    logic  cand;
    nxt  = cur;
    cand = sel_req ? in1 : in0;
    if (!used) begin
      nxt = CELL_RESET;
    end else if (!cur.clk && !cand) begin
      // safe point: output low and new source low, so no runt pulse
      nxt.sel   = sel_req;
      nxt.state = en ? CELL_ON : CELL_OFF;
      nxt.clk   = 1'b0;
    end else begin
      nxt.clk = (cur.state == CELL_ON) && (cur.sel ? in1 : in0);
    end
    return nxt;
  endfunction

  // input zero of a cell: the even pin of the pair, or internal logic
  function automatic logic src_in0(input net_cfg_t cfg, input logic logic_clk,
                                   input logic [NUM_PINS-1:0] pins);
    logic v;
    v = pins[{cfg.pin_pair, 1'b0}];
    if (cfg.kind == SRC_LOGIC) begin
      v = logic_clk;
    end
    return v;
  endfunction

  // input one: odd pin of the pair, a pll output, or internal logic
  function automatic logic src_in1(input net_cfg_t cfg, input logic logic_clk,
                                   input logic [NUM_PINS-1:0] pins,
                                   input logic [NUM_PLL_OUT-1:0] plls);
    logic v;
    case (cfg.kind)
      SRC_PIN:   v = pins[{cfg.pin_pair, 1'b1}];
      SRC_PLL:   v = plls[cfg.pll_sel];
      SRC_LOGIC: v = logic_clk;
      default:   v = 1'b0;
    endcase
    return v;
  endfunction

  // next state of every cell and of the per-quadrant clock bundles
  always_comb begin
    for (int g = 0; g < NUM_GLOBAL; g++) begin
      // run-time select only here; logic sources ignore it since both inputs match
      next_gcell[g] = cell_step(gcell[g], global_cfg[g].used, global_en[g],
                                global_sel[g],
                                src_in0(global_cfg[g], global_logic_clk[g], dedicated_clock_pin),
                                src_in1(global_cfg[g], global_logic_clk[g], dedicated_clock_pin,
                                        pll_clk));
    end
    for (int r = 0; r < NUM_REGIONAL; r++) begin
      // regional select is fixed by configuration, never by core logic
      next_rcell[r] = cell_step(rcell[r], regional_cfg[r].used, regional_en[r],
                                (regional_cfg[r].kind == SRC_PLL) || regional_cfg[r].pin_odd,
                                src_in0(regional_cfg[r], regional_logic_clk[r],
                                        dedicated_clock_pin),
                                src_in1(regional_cfg[r], regional_logic_clk[r],
                                        dedicated_clock_pin, pll_clk));
    end
    for (int p = 0; p < NUM_PLL_OUT; p++) begin
      // pad gate sits after the pll; the pll clock itself is never touched
      next_pcell[p] = cell_step(pcell[p], 1'b1, pll_pad_en[p], 1'b0,
                                pll_clk[p], pll_clk[p]);
    end
    for (int q = 0; q < NUM_QUADRANTS; q++) begin
      for (int g = 0; g < NUM_GLOBAL; g++) begin
        next_region[q].global_clk[g] = next_gcell[g].clk;
      end
      for (int k = 0; k < REGIONAL_PER_QUADRANT; k++) begin
        next_region[q].regional_clk[k] =
          next_rcell[q*REGIONAL_PER_QUADRANT + k].clk;
      end
    end
  end

  // registers; the outputs come straight from these flops
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      gcell         <= {NUM_GLOBAL{CELL_RESET}};
      rcell         <= {NUM_REGIONAL{CELL_RESET}};
      pcell         <= {NUM_PLL_OUT{CELL_RESET}};
      region_clocks <= '0;
    end else begin
      gcell         <= next_gcell;
      rcell         <= next_rcell;
      pcell         <= next_pcell;
      region_clocks <= next_region;
    end
  end

  // flat views of the cell output flops
  always_comb begin
    for (int g = 0; g < NUM_GLOBAL; g++) begin
      global_clock_net[g] = gcell[g].clk;
    end
    for (int r = 0; r < NUM_REGIONAL; r++) begin
      regional_clock_net[r] = rcell[r].clk;
    end
    for (int p = 0; p < NUM_PLL_OUT; p++) begin
      pll_out_pad[p] = pcell[p].clk;
    end
  end

endmodule

`default_nettype wire

// [bench/clock_network_control_properties.sv]
// assertion checker for the clock network control block
`timescale 1ns/1ps
`default_nettype none
module clock_network_control_properties
  import clock_network_pkg::*;
(
  input wire logic                 ref_clk,
  input wire logic                 rst,
  input wire logic [15:0]          dedicated_clock_pin,
  input wire logic [7:0]           pll_clk,
  input wire logic [15:0]          global_logic_clk,
  input wire net_cfg_t [15:0]      global_cfg,
  input wire logic [15:0]          global_en,
  input wire logic [7:0]           pll_pad_en,
  input wire logic [15:0]          global_clock_net,
  input wire logic [31:0]          regional_clock_net,
  input wire logic [7:0]           pll_out_pad,
  input wire region_clocks_t [3:0] region_clocks
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // all pins, pll outputs and global logic clocks low, so the cell of global net 0 may change state
  wire logic z = ~|{dedicated_clock_pin, pll_clk, global_logic_clk};
  property p_unused; !global_cfg[0].used |=> !global_clock_net[0]; endproperty
  a_unused: assert property (p_unused) else $error("unused net ran");
  property p_src; global_clock_net[0] |-> $past(!z); endproperty
  a_src: assert property (p_src) else $error("net high without source");
  property p_pad; pll_out_pad[3] |-> $past(pll_clk[3]); endproperty
  a_pad: assert property (p_pad) else $error("pad high without pll");
  property p_pad_on; pll_pad_en[3] && !pll_clk[3] && !pll_out_pad[3] ##1 pll_clk[3]
    |=> pll_out_pad[3]; endproperty
  a_pad_on: assert property (p_pad_on) else $error("pad enable lost");
  property p_pad_off; !pll_pad_en[3] && !pll_clk[3] && !pll_out_pad[3] ##1 !pll_pad_en[3]
    |=> !pll_out_pad[3]; endproperty
  a_pad_off: assert property (p_pad_off) else $error("pad ran while off");
  property p_off; global_cfg[0].used && !global_en[0] && z && !global_clock_net[0]
    ##1 !global_en[0] |=> !global_clock_net[0]; endproperty
  a_off: assert property (p_off) else $error("net ran while off");
  property p_quad; region_clocks[0].global_clk == global_clock_net
    && region_clocks[3].global_clk == global_clock_net; endproperty
  a_quad: assert property (p_quad) else $error("global missing in quadrant");
  property p_reg; region_clocks[1].regional_clk == regional_clock_net[15:8]; endproperty
  a_reg: assert property (p_reg) else $error("regional misrouted");
endmodule
bind clock_network_control clock_network_control_properties
  clock_network_control_properties_i (.*);
`default_nettype wire

// [bench/clocked_resource_model.sv]
// clocked resource on a global net: counts the edges it receives
`timescale 1ns/1ps
`default_nettype none
module clocked_resource_model (
  input  wire logic rst,
  input  wire logic net_clk,
  output var  int   edges
);
  // async clear, since a stopped net could never clear it
  always_ff @(posedge net_clk or posedge rst) begin
    if (rst) begin
      edges <= 0;
    end else begin
      edges <= edges + 1;
    end
  end
endmodule
`default_nettype wire

// [bench/clock_network_control_tb.sv]
// self-checking bench for the clock network control block
`timescale 1ns/1ps
`default_nettype none
module clock_network_control_tb;
  import clock_network_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, ph = 1'b0, run = 1'b0, was = 1'b0;
  logic [15:0] pin_m = '0, gen = '0, gsel = '0, glog_m = '0, gnet;
  logic [7:0] pll_m = '0, pen = '0, pad;
  logic [31:0] rlog_m = '0, ren = '0, rnet;
  net_cfg_t [15:0] gcfg = '0;
  net_cfg_t [31:0] rcfg = '0;
  region_clocks_t [3:0] rc;
  int edges, e, n_mismatch = 0, n_checks = 0;
  // sources toggle with ph only where their mask is set
  clock_network_control clock_network_control_i (.ref_clk(ref_clk), .rst(rst),
    .dedicated_clock_pin(ph ? pin_m : 16'h0), .pll_clk(ph ? pll_m : 8'h0),
    .global_logic_clk(ph ? glog_m : 16'h0), .regional_logic_clk(ph ? rlog_m : 32'h0),
    .global_cfg(gcfg), .regional_cfg(rcfg), .global_en(gen), .global_sel(gsel),
    .regional_en(ren), .pll_pad_en(pen), .global_clock_net(gnet),
    .regional_clock_net(rnet), .pll_out_pad(pad), .region_clocks(rc));
  clocked_resource_model clocked_resource_model_i (.rst(rst), .net_clk(gnet[0]), .edges(edges));
  always #4 ref_clk = ~ref_clk;
  task automatic chk(input logic [55:0] seen, input logic [55:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc;
    @(posedge ref_clk);
    was = ph;
    ph <= run & ~ph;
  endtask
  // nets must be quiet before reconfiguring, else changes are held off
  task automatic settle;
    cyc();
    run <= 1'b0;
    repeat (2) cyc();
  endtask
  // output follows its source one edge late: {global, pad, regional}
  task automatic look(input int n, input logic [55:0] m);
    repeat (n) begin
      cyc();
      #1;
      chk({gnet, pad, rnet}, was ? m : '0);
      for (int q = 0; q < 4; q++) chk({rc[q], 32'h0}, was ? {m[55:40], m[8*q +: 8], 32'h0} : '0);
    end
  endtask
  task automatic t_pin;
    settle();
    gcfg[0] <= '{1'b1, SRC_PIN, 3'h0, 1'b0, 3'h0};
    pin_m <= 16'h1;
    gen <= 16'h1;
    run <= 1'b1;
    look(6, 56'h1 << 40);
    settle();
    gsel <= 16'h1;
    run <= 1'b1;
    look(4, '0);
    settle();
    pin_m <= 16'h2;
    run <= 1'b1;
    look(4, 56'h1 << 40);
    $display("t_pin done");
  endtask
  task automatic t_pll;
    settle();
    gcfg[0] <= '{1'b1, SRC_PLL, 3'h0, 1'b0, 3'h3};
    pll_m <= 8'h08;
    pen <= 8'h08;
    run <= 1'b1;
    look(4, (56'h1 << 40) | (56'h8 << 32));
    settle();
    e = edges;
    gen <= 16'h0;
    run <= 1'b1;
    look(4, 56'h8 << 32);
    chk(56'(edges - e), '0);
    $display("t_pll done");
  endtask
  task automatic t_unused;
    settle();
    gcfg[0].used <= 1'b0;
    gen <= 16'h1;
    pen <= 8'h0;
    run <= 1'b1;
    look(4, '0);
    $display("t_unused done");
  endtask
  task automatic t_reg;
    settle();
    rcfg[9] <= '{1'b1, SRC_LOGIC, 3'h0, 1'b0, 3'h0};
    rlog_m <= 32'h200;
    ren <= 32'h200;
    gcfg[1] <= '{1'b1, SRC_LOGIC, 3'h0, 1'b0, 3'h0};
    glog_m <= 16'h2;
    gen <= 16'h2;
    run <= 1'b1;
    look(4, (56'h2 << 40) | 56'h200);
    $display("t_reg done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    t_pin();
    t_pll();
    t_unused();
    t_reg();
    tally_and_finish();
  end
  // the tests need well under 100 cycles
  initial begin
    #20000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
